// File: rtl/hdpc_pkg.sv
/*
  hdpc_pkg: constants shared by the downstream port power and charging block.
  assumes a single 10 MHz clock domain and a plain register port.
*/
package hdpc_pkg;
  localparam int NUM_PORTS = 4;
  localparam int CLK_HZ = 10_000_000;

  // register indices (byte address = word index, plain port)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PWR_REQ = 4'h1;
  localparam logic [3:0] ADDR_USB2_ONLY = 4'h2;
  localparam logic [3:0] ADDR_CHG_EN = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
  localparam logic [3:0] ADDR_PORT_STATE = 4'h7;

  // control register fields
  localparam int CTRL_GANGED = 0;
  localparam int CTRL_AUTO_CHG = 1;
  localparam int CTRL_CHG_LSB = 2;
  localparam int CTRL_CHG_W = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // status register fields
  localparam int STAT_UP_CONN = 0;
  localparam int STAT_UP_CFG = 1;
  localparam int STAT_SS_DIS = 2;
  localparam int STAT_HS_DIS = 3;
  localparam int STAT_MODE_LSB = 4;

  // irq layout: bits 3:0 over-current per port, bit 4 upstream change
  localparam int IRQ_UP_CHG = 4;
  localparam int IRQ_W = 5;

  // upstream link capability codes
  localparam logic [1:0] UP_SS = 2'h0;
  localparam logic [1:0] UP_HS = 2'h1;
  localparam logic [1:0] UP_FS = 2'h2;

  // time spent in each step of the automatic charging walk
  localparam int AUTO_STEP_MS = 1000;
  localparam int AUTO_STEP_CYC = CLK_HZ / 1000 * AUTO_STEP_MS;

  // charging behaviour of the downstream ports
  typedef enum logic [2:0] {
    CHG_OFF,
    CHG_CDP,
    CHG_DCP,
    CHG_DIV1,
    CHG_DIV2,
    CHG_DIV3,
    CHG_AUTO
  } hdpc_chg_t;
endpackage : hdpc_pkg

// File: rtl/hdpc_port_power.sv
/*
  hdpc_port_power: power switch control for one downstream port.
  assumes over-current input is already synchronous to clk_in.
*/
module hdpc_port_power (
  // clock and control
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // requests
  input wire logic pwr_want_in,
  input wire logic oc_trip_in,
  // switch drive
  output logic pwr_en_out,
  output logic oc_event_out
);
  logic oc_seen;

  // power follows the request; over-current forces off until re-requested
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pwr_en_out <= 1'b0;
      oc_seen <= 1'b0;
    end else if (ce_in) begin
      if (oc_trip_in) begin
        pwr_en_out <= 1'b0;
        oc_seen <= 1'b1;
      end else if (!pwr_want_in) begin
        pwr_en_out <= 1'b0;
        oc_seen <= 1'b0; // host drops request to re-arm
      end else if (!oc_seen) begin
        pwr_en_out <= 1'b1;
      end
    end
  end

  // one pulse on the rising edge of a trip
  logic oc_prev;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      oc_prev <= 1'b0;
      oc_event_out <= 1'b0;
    end else if (ce_in) begin
      oc_prev <= oc_trip_in;
      oc_event_out <= oc_trip_in & ~oc_prev;
    end
  end
endmodule : hdpc_port_power

// File: rtl/hdpc_charge_seq.sv
/*
  hdpc_charge_seq: chooses the charging behaviour shared by all ports.
  assumes upstream connected and configured levels are synchronous.
*/
module hdpc_charge_seq (
  // clock and control
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // selection
  input wire logic auto_in,
  input wire logic [2:0] sel_in,
  input wire logic up_conn_in,
  input wire logic up_cfg_in,
  // result
  output hdpc_pkg::hdpc_chg_t mode_out
);
  logic [31:0] step_cnt;
  hdpc_pkg::hdpc_chg_t auto_mode;
  hdpc_pkg::hdpc_chg_t sel_mode;
  hdpc_pkg::hdpc_chg_t next_mode;
  logic div_ok;

  assign sel_mode = hdpc_pkg::hdpc_chg_t'(sel_in);
  assign div_ok = !up_conn_in || !up_cfg_in;

  // automatic walk: divider three, two, one, then dedicated and stay
  // restart only while enabled, so a low clock enable freezes the walk too
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      auto_mode <= hdpc_pkg::CHG_DIV3;
      step_cnt <= '0;
    end else if (ce_in) begin
      if (up_conn_in || !auto_in) begin
        auto_mode <= hdpc_pkg::CHG_DIV3;
        step_cnt <= '0;
      end else if (auto_mode != hdpc_pkg::CHG_DCP) begin
        if (step_cnt == 32'(hdpc_pkg::AUTO_STEP_CYC - 1)) begin
          step_cnt <= '0;
          case (auto_mode)
            hdpc_pkg::CHG_DIV3: auto_mode <= hdpc_pkg::CHG_DIV2;
            hdpc_pkg::CHG_DIV2: auto_mode <= hdpc_pkg::CHG_DIV1;
            default: auto_mode <= hdpc_pkg::CHG_DCP;
          endcase
        end else begin
          step_cnt <= step_cnt + 32'h0000_0001;
        end
      end
    end
  end

  // resolve the mode allowed by the upstream state
  always_comb begin
    next_mode = hdpc_pkg::CHG_OFF;
    if (up_conn_in) begin
      if (sel_mode != hdpc_pkg::CHG_OFF) begin
        next_mode = hdpc_pkg::CHG_CDP;
      end
      if (!up_cfg_in && (sel_mode == hdpc_pkg::CHG_DIV1 || sel_mode == hdpc_pkg::CHG_DIV2 ||
          sel_mode == hdpc_pkg::CHG_DIV3)) begin
        next_mode = sel_mode;
      end
    end else if (auto_in) begin
      next_mode = auto_mode;
    end else begin
      case (sel_mode)
        hdpc_pkg::CHG_OFF: next_mode = hdpc_pkg::CHG_OFF;
        hdpc_pkg::CHG_DIV1, hdpc_pkg::CHG_DIV2, hdpc_pkg::CHG_DIV3:
          next_mode = div_ok ? sel_mode : hdpc_pkg::CHG_OFF;
        default: next_mode = hdpc_pkg::CHG_DCP;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mode_out <= hdpc_pkg::CHG_OFF;
    end else if (ce_in) begin
      mode_out <= next_mode;
    end
  end
endmodule : hdpc_charge_seq

// File: rtl/hdpc_top.sv
/*
  hdpc_top: downstream port power, speed limiting and charging control.
  assumes all inputs synchronous to clk_in; external switches take the enables.
*/
// What this block does
// - individual mode: each port follows host request
// - individual over-current cuts only that port
// - ganged: any request powers all ports
// - ganged power stays while any port needs
// - ganged over-current cuts all ports
// - upstream high-speed only disables downstream SuperSpeed
// - upstream full/low only disables SuperSpeed, high-speed
// - upstream connected: charging ports do CDP
// - upstream unconnected: charging ports act dedicated
// - divider modes only unconnected or unconfigured
// - auto mode walks divider three to dedicated
// - each port may be USB 2.0 only
module hdpc_top (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // upstream state
  input wire logic up_conn_in,
  input wire logic up_cfg_in,
  input wire logic [1:0] up_speed_in,
  // downstream pins
  input wire logic [3:0] oc_in,
  output logic [3:0] pwr_en_out,
  output logic [3:0] ss_en_out,
  output logic [3:0] hs_en_out,
  output logic [3:0] chg_en_out,
  output logic [2:0] chg_mode_out,
  // interrupt
  output logic irq_out
);
  localparam int N = hdpc_pkg::NUM_PORTS;

  logic [7:0] ctrl;
  logic [3:0] pwr_req;
  logic [3:0] usb2_only;
  logic [3:0] chg_en;
  logic [4:0] irq_stat;
  logic [4:0] irq_mask;
  logic ganged;
  logic [3:0] want;
  logic [3:0] trip;
  logic [3:0] sw_en;
  logic [3:0] oc_evt;
  logic up_conn_prev;
  logic ss_dis;
  logic hs_dis;
  hdpc_pkg::hdpc_chg_t mode;
  logic [7:0] status;

  assign ganged = ctrl[hdpc_pkg::CTRL_GANGED];

  // ganged: one shared request and one shared trip feed every port
  always_comb begin
    if (ganged) begin
      want = {N{|pwr_req}};
      trip = {N{|oc_in}};
    end else begin
      want = pwr_req;
      trip = oc_in;
    end
  end

  // one switch controller per port
  for (genvar i = 0; i < N; i++) begin : g_port
    hdpc_port_power u_pwr (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .ce_in(ce_in),
      .pwr_want_in(want[i]),
      .oc_trip_in(trip[i]),
      .pwr_en_out(sw_en[i]),
      .oc_event_out(oc_evt[i])
    );
  end

  assign pwr_en_out = sw_en; // flops inside the port module

  hdpc_charge_seq u_chg (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .auto_in(ctrl[hdpc_pkg::CTRL_AUTO_CHG]),
    .sel_in(ctrl[hdpc_pkg::CTRL_CHG_LSB +: hdpc_pkg::CTRL_CHG_W]),
    .up_conn_in(up_conn_in),
    .up_cfg_in(up_cfg_in),
    .mode_out(mode)
  );

  assign ss_dis = (up_speed_in != hdpc_pkg::UP_SS);
  assign hs_dis = (up_speed_in >= hdpc_pkg::UP_FS); // codes 2 and 3 are both full/low

  // speed limits and charging outputs, all registered
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ss_en_out <= 4'h0;
      hs_en_out <= 4'h0;
      chg_en_out <= 4'h0;
      chg_mode_out <= 3'h0;
    end else if (ce_in) begin
      ss_en_out <= ss_dis ? 4'h0 : ~usb2_only;
      hs_en_out <= hs_dis ? 4'h0 : 4'hf;
      chg_en_out <= (mode == hdpc_pkg::CHG_OFF) ? 4'h0 : chg_en;
      chg_mode_out <= 3'(mode);
    end
  end

  // register writes
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl <= hdpc_pkg::CTRL_RESET;
      pwr_req <= 4'h0;
      usb2_only <= 4'h0;
      chg_en <= 4'h0;
      irq_mask <= 5'h00;
    end else if (ce_in && wr_in) begin
      case (addr_in)
        hdpc_pkg::ADDR_CTRL: ctrl <= wdata_in;
        hdpc_pkg::ADDR_PWR_REQ: pwr_req <= wdata_in[3:0];
        hdpc_pkg::ADDR_USB2_ONLY: usb2_only <= wdata_in[3:0];
        hdpc_pkg::ADDR_CHG_EN: chg_en <= wdata_in[3:0];
        hdpc_pkg::ADDR_IRQ_MASK: irq_mask <= wdata_in[4:0];
        default: ;
      endcase
    end
  end

  // sticky events; a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_stat <= 5'h00;
      up_conn_prev <= 1'b0;
    end else if (ce_in) begin
      up_conn_prev <= up_conn_in;
      irq_stat <= (irq_stat & ~((wr_in && addr_in == hdpc_pkg::ADDR_IRQ_STAT) ?
                   wdata_in[4:0] : 5'h00))
                  | {up_conn_in ^ up_conn_prev, oc_evt};
    end
  end

  // level interrupt, registered so it is a clean flop output
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_out <= 1'b0;
    end else if (ce_in) begin
      irq_out <= |(irq_stat & irq_mask);
    end
  end

  assign status = {1'b0, 3'(mode), hs_dis, ss_dis, up_cfg_in, up_conn_in};

  // read data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_out <= 8'h00;
    end else if (ce_in) begin
      rdata_out <= 8'h00;
      if (rd_in) begin
        case (addr_in)
          hdpc_pkg::ADDR_CTRL: rdata_out <= ctrl;
          hdpc_pkg::ADDR_PWR_REQ: rdata_out <= {4'h0, pwr_req};
          hdpc_pkg::ADDR_USB2_ONLY: rdata_out <= {4'h0, usb2_only};
          hdpc_pkg::ADDR_CHG_EN: rdata_out <= {4'h0, chg_en};
          hdpc_pkg::ADDR_STATUS: rdata_out <= status;
          hdpc_pkg::ADDR_IRQ_STAT: rdata_out <= {3'h0, irq_stat};
          hdpc_pkg::ADDR_IRQ_MASK: rdata_out <= {3'h0, irq_mask};
          hdpc_pkg::ADDR_PORT_STATE: rdata_out <= {oc_in, sw_en};
          default: rdata_out <= 8'h00;
        endcase
      end
    end
  end
endmodule : hdpc_top

// File: verif/hdpc_switch_model.sv
/*
  hdpc_switch_model: four external port power switches with load faults.
  assumes fault_in is set by the bench; a fault draws current only while powered.
*/
module hdpc_switch_model (
  // switch side
  input wire logic [3:0] pwr_en_in,
  input wire logic [3:0] fault_in,
  output logic [3:0] oc_out
);
  // one flag per switch; a dead switch cannot report over-current
  assign oc_out = pwr_en_in & fault_in;
endmodule : hdpc_switch_model

// File: verif/hdpc_chk_sva.sv
/*
  hdpc_chk: port power, speed and charging properties of hdpc_top.
  assumes ce_in high during checks; shadows control writes itself.
*/
module hdpc_chk (
  // watched ports
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic up_conn_in,
  input wire logic up_cfg_in,
  input wire logic [1:0] up_speed_in,
  input wire logic [3:0] oc_in,
  input wire logic [3:0] pwr_en_out,
  input wire logic [3:0] ss_en_out,
  input wire logic [3:0] hs_en_out,
  input wire logic [2:0] chg_mode_out
);
  logic gang;
  logic [2:0] sel;
  logic [3:0] u2;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in || !ce_in);
  // shadow copies, since register contents are not visible at the ports
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      gang <= 1'b0;
      sel <= 3'h0;
      u2 <= 4'h0;
    end else if (ce_in && wr_in && addr_in == hdpc_pkg::ADDR_CTRL) begin
      gang <= wdata_in[0];
      sel <= wdata_in[4:2];
    end else if (ce_in && wr_in && addr_in == hdpc_pkg::ADDR_USB2_ONLY) begin
      u2 <= wdata_in[3:0];
    end
  end
  sequence s_req_write;
    wr_in && addr_in == hdpc_pkg::ADDR_PWR_REQ && !gang && oc_in == 4'h0 ##1 oc_in == 4'h0;
  endsequence
  sequence s_cdp_held;
    (sel != 3'h0 && up_conn_in && up_cfg_in)[*3];
  endsequence
  a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data outside read slot");
  a_req_follow: assert property (s_req_write |=> pwr_en_out == $past(wdata_in[3:0], 2))
    else $error("power does not follow request");
  a_oc_single: assert property (!gang && (oc_in & pwr_en_out) != 4'h0
    |=> pwr_en_out == ($past(pwr_en_out) & ~$past(oc_in))) else $error("wrong ports cut");
  a_gang_all: assert property (gang && $past(gang, 2)
    |-> pwr_en_out == 4'h0 || pwr_en_out == 4'hf) else $error("ganged ports differ");
  a_gang_trip: assert property (gang && oc_in != 4'h0 |=> pwr_en_out == 4'h0)
    else $error("ganged trip left power on");
  a_hs_limit: assert property (up_speed_in == hdpc_pkg::UP_HS |=> ss_en_out == 4'h0)
    else $error("superspeed left on");
  a_fs_limit: assert property (up_speed_in[1] |=> (ss_en_out | hs_en_out) == 4'h0)
    else $error("fast speeds left on");
  a_cdp_conn: assert property (s_cdp_held |-> chg_mode_out == 3'h1)
    else $error("no cdp while connected");
  a_div_gate: assert property (chg_mode_out inside {3'h3, 3'h4, 3'h5}
    |-> !$past(up_conn_in && up_cfg_in, 2)) else $error("divider while configured");
  a_usb2_port: assert property (1'b1 |=> (ss_en_out & $past(u2)) == 4'h0)
    else $error("superspeed on usb2-only port");
endmodule : hdpc_chk

bind hdpc_top hdpc_chk hdpc_chk_inst (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .up_conn_in(up_conn_in), .up_cfg_in(up_cfg_in), .up_speed_in(up_speed_in), .oc_in(oc_in),
  .pwr_en_out(pwr_en_out), .ss_en_out(ss_en_out), .hs_en_out(hs_en_out),
  .chg_mode_out(chg_mode_out));

// File: verif/hdpc_tb_top.sv
/*
  hdpc_tb_top: self-checking bench for hdpc_top with switch model.
  assumes ce_in high except in the freeze test; reads queued, checked on answer.
*/
module hdpc_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic up_conn_in = 1'b0;
  logic up_cfg_in = 1'b0;
  logic [1:0] up_speed_in = 2'h0;
  logic [3:0] fault = 4'h0;
  logic [3:0] oc_in;
  logic [3:0] pwr_en_out;
  logic [3:0] ss_en_out;
  logic [3:0] hs_en_out;
  logic [3:0] chg_en_out;
  logic ce_in = 1'b1;
  logic [7:0] rdata_out;
  logic irq_out;
  logic rd_d = 1'b0;
  logic [2:0] m;
  logic [7:0] exp_q[$];
  logic [15:0] lfsr = 16'h0539;
  int err_total = 0;
  int n_checks = 0;
  always #50 clk_in = ~clk_in;
  hdpc_top hdpc_top_inst (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .up_conn_in(up_conn_in), .up_cfg_in(up_cfg_in), .up_speed_in(up_speed_in), .oc_in(oc_in),
    .pwr_en_out(pwr_en_out), .ss_en_out(ss_en_out), .hs_en_out(hs_en_out),
    .chg_en_out(chg_en_out), .chg_mode_out(), .irq_out(irq_out));
  hdpc_switch_model hdpc_switch_model_inst (.pwr_en_in(pwr_en_out), .fault_in(fault),
    .oc_out(oc_in));
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask : rd
  // sampled at the falling edge, away from the edge that launches the flop
  task automatic chk_irq(input logic e);
    @(negedge clk_in);
    n_checks++;
    if (irq_out !== e) begin
      err_total++;
      $display("[ERR] %0t irq %b", $time, irq_out);
    end
    @(posedge clk_in);
  endtask : chk_irq
  // pins that no read shows: speed limits and charging enables
  task automatic chk_pins(input logic [3:0] s, input logic [3:0] h, input logic [3:0] c);
    @(negedge clk_in);
    n_checks++;
    if (ss_en_out !== s || hs_en_out !== h || chg_en_out !== c) begin
      err_total++;
      $display("[ERR] %0t pins %h %h %h", $time, ss_en_out, hs_en_out, chg_en_out);
    end
    @(posedge clk_in);
  endtask : chk_pins
  // pseudo-random source for the random scenario
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  // status image built from the current upstream inputs
  function automatic logic [7:0] st(input logic [2:0] md);
    return {1'b0, md, up_speed_in[1], up_speed_in != 2'h0, up_cfg_in, up_conn_in};
  endfunction : st
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // answer monitor: one queued note per read
  always @(posedge clk_in) begin
    if (rd_d) begin
      n_checks++;
      if (exp_q.size() == 0 || rdata_out !== exp_q[0]) begin
        err_total++;
        $display("[ERR] %0t read %h", $time, rdata_out);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    rd_d <= rd_in;
  end
  // about 500 cycles of work; eight times that means a hang
  initial begin
    #400000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(hdpc_pkg::ADDR_CTRL, 8'h00);
    wr(hdpc_pkg::ADDR_STATUS, 8'hff);
    wr(4'h8, 8'hff);
    rd(4'h8, 8'h00);
    rd(hdpc_pkg::ADDR_STATUS, st(3'h0));
    wr(hdpc_pkg::ADDR_PWR_REQ, 8'h05);
    rd(hdpc_pkg::ADDR_PORT_STATE, 8'h05);
    fault <= 4'h4;
    wr(hdpc_pkg::ADDR_IRQ_MASK, 8'h00);
    rd(hdpc_pkg::ADDR_PORT_STATE, 8'h01);
    chk_irq(1'b0);
    fault <= 4'h0;
    wr(hdpc_pkg::ADDR_IRQ_MASK, 8'h04);
    chk_irq(1'b1);
    rd(hdpc_pkg::ADDR_IRQ_STAT, 8'h04);
    wr(hdpc_pkg::ADDR_IRQ_STAT, 8'h04);
    chk_irq(1'b0);
    wr(hdpc_pkg::ADDR_PWR_REQ, 8'h01);
    wr(hdpc_pkg::ADDR_PWR_REQ, 8'h05);
    rd(hdpc_pkg::ADDR_PORT_STATE, 8'h05);
    $display("done individual power");
    wr(hdpc_pkg::ADDR_PWR_REQ, 8'h00);
    wr(hdpc_pkg::ADDR_CTRL, 8'h01);
    wr(hdpc_pkg::ADDR_PWR_REQ, 8'h01);
    rd(hdpc_pkg::ADDR_PORT_STATE, 8'h0f);
    wr(hdpc_pkg::ADDR_PWR_REQ, 8'h02);
    rd(hdpc_pkg::ADDR_PORT_STATE, 8'h0f);
    fault <= 4'h8;
    wr(hdpc_pkg::ADDR_IRQ_MASK, 8'h00);
    rd(hdpc_pkg::ADDR_PORT_STATE, 8'h00);
    fault <= 4'h0;
    wr(hdpc_pkg::ADDR_PWR_REQ, 8'h00);
    wr(hdpc_pkg::ADDR_CTRL, 8'h00);
    $display("done ganged power");
    wr(hdpc_pkg::ADDR_CHG_EN, 8'h0b);
    for (int s = 1; s < 6; s++) begin
      for (int c = 0; c < 3; c++) begin
        up_conn_in <= c > 0;
        up_cfg_in <= c > 1;
        wr(hdpc_pkg::ADDR_CTRL, {3'h0, s[2:0], 2'h0});
        m = (c == 2 || (c == 1 && s < 3)) ? 3'h1 : (s < 3 ? 3'h2 : s[2:0]);
        rd(hdpc_pkg::ADDR_STATUS, st(m));
        chk_pins(4'hf, 4'hf, 4'hb);
      end
    end
    up_conn_in <= 1'b0;
    up_cfg_in <= 1'b0;
    wr(hdpc_pkg::ADDR_CTRL, 8'h02);
    rd(hdpc_pkg::ADDR_STATUS, st(3'h5));
    wr(hdpc_pkg::ADDR_CTRL, 8'h00);
    $display("done charging");
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      up_speed_in <= lfsr[5:4];
      wr(hdpc_pkg::ADDR_USB2_ONLY, {4'h0, lfsr[11:8]});
      wr(hdpc_pkg::ADDR_PWR_REQ, {4'h0, lfsr[3:0]});
      rd(hdpc_pkg::ADDR_PORT_STATE, {4'h0, lfsr[3:0]});
      rd(hdpc_pkg::ADDR_STATUS, st(3'h0));
      chk_pins(up_speed_in != 2'h0 ? 4'h0 : ~lfsr[11:8], up_speed_in[1] ? 4'h0 : 4'hf, 4'h0);
    end
    $display("done random");
    // a write while the clock enable is low must not land
    ce_in <= 1'b0;
    wr(hdpc_pkg::ADDR_PWR_REQ, 8'h00);
    ce_in <= 1'b1;
    rd(hdpc_pkg::ADDR_PWR_REQ, {4'h0, lfsr[3:0]});
    // second reset in mid-run brings power and requests back to zero
    srst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(hdpc_pkg::ADDR_PWR_REQ, 8'h00);
    rd(hdpc_pkg::ADDR_PORT_STATE, 8'h00);
    chk_irq(1'b0);
    $display("done freeze and reset");
    print_verdict();
  end
endmodule : hdpc_tb_top
